// [rtl/accel_queue_pkg.sv]
// What this block does
// - Store 320 sixteen-bit sample words.
// - Three channels enabled: only 318 words used.
// - Store enabled channels X,Y,Z,T from location 0.
// - Data register address never auto-increments.
// - Lower start addresses increment, then hold there.
// - Config bit enables channel tags.
// - Tagging emits 2-bit channel tag before sample.
// - Tags: X 00, Y 01, Z 10, T 11.
// - Tags made at read-out, use no storage.
// - Burst read gives tag then sample per channel.
// - Trigger mode freezes pre-event history.
// - Mode field: off, stop, overwrite, trigger.
// - Full flag at 320, or 318 words.
// - Ready flag while any sample is held.
package accel_queue_pkg;

  localparam logic [7:0] QUEUE_READ_PORT_ADDR   = 8'h1d;
  localparam logic [7:0] QUEUE_CONFIG_LOW_ADDR  = 8'h30;
  localparam logic [7:0] QUEUE_CONFIG_LOW_RESET = 8'h00;
  localparam int         TAG_ENABLE_BIT         = 6;
  localparam int         MODE_LSB               = 4;

  localparam int         QUEUE_WORDS     = 320;
  localparam logic [8:0] CAP_FULL        = 9'h140;
  localparam logic [8:0] CAP_THREE_CHAN  = 9'h13e;
  localparam int         SAMPLE_W        = 16;
  localparam int         INPUT_FIFO_DEPTH = 32;

  localparam logic [1:0] TAG_X = 2'h0;
  localparam logic [1:0] TAG_Y = 2'h1;
  localparam logic [1:0] TAG_Z = 2'h2;
  localparam logic [1:0] TAG_T = 2'h3;

  typedef enum logic [1:0] {
    MODE_OFF       = 2'b00,
    MODE_STOP      = 2'b01,
    MODE_OVERWRITE = 2'b10,
    MODE_TRIGGER   = 2'b11
  } queue_mode_t;

  typedef enum logic [1:0] {
    PH_TAG  = 2'b00,
    PH_LOW  = 2'b01,
    PH_HIGH = 2'b10
  } byte_phase_t;

endpackage

// [rtl/sample_fifo.sv]
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    fill;
  logic             out_v;
  logic [WIDTH-1:0] out_q;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_fill;
  logic             next_out_v;
  logic             push;
  logic             load;

  // The output register adds one word of storage beyond DEPTH.
  assign in_ready_out  = (fill != CW'(DEPTH));
  assign out_valid_out = out_v;
  assign out_data_out  = out_q;

  always_comb begin
    push        = in_valid_in && in_ready_out;
    load        = (fill != '0) && (!out_v || out_ready_in);
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_fill   = fill;
    next_out_v  = out_v && !out_ready_in;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
    end
    if (load) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      next_out_v  = 1'b1;
    end
    next_fill = fill + CW'(push) - CW'(load);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
      out_v  <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill   <= next_fill;
      out_v  <= next_out_v;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
    if (!rst_n_in) begin
      out_q <= '0;
    end else if (load) begin
      out_q <= mem[rd_ptr];
    end
  end

endmodule

// [rtl/accel_sample_queue.sv]
`timescale 1ns/100ps
module accel_sample_queue
  import accel_queue_pkg::*;
(
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        REG_START_IN,
  input  wire logic [7:0]  REG_ADDR_IN,
  input  wire logic        REG_RD_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic [7:0]  REG_WDATA_IN,
  output logic      [7:0]  REG_RDATA_OUT,
  output logic             REG_RVALID_OUT,
  input  wire logic [3:0]  CHAN_ENABLE_IN,
  input  wire logic        SAMPLE_VALID_IN,
  input  wire logic [1:0]  SAMPLE_CHAN_IN,
  input  wire logic [15:0] SAMPLE_DATA_IN,
  output logic             SAMPLE_READY_OUT,
  input  wire logic        TRIGGER_IN,
  input  wire logic [8:0]  TRIGGER_SAMPLES_IN,
  output logic             QUEUE_FULL_OUT,
  output logic             QUEUE_READY_OUT,
  output logic             QUEUE_FROZEN_OUT
);

  // Slot n of a sample set holds the n-th enabled channel.
  function automatic logic [1:0] slot_chan(input logic [3:0] en, input logic [1:0] slot);
    logic [1:0] n;
    logic [1:0] r;
    n = 2'h0;
    r = TAG_X;
    for (int i = 0; i < 4; i++) begin
      if (en[i]) begin
        if (n == slot) begin
          r = 2'(i);
        end
        n = n + 2'h1;
      end
    end
    return r;
  endfunction

  function automatic logic [8:0] ptr_add(input logic [8:0] p, input logic [2:0] n,
                                         input logic [8:0] cap);
    logic [9:0] s;
    s = {1'b0, p} + {7'h00, n};
    if (s >= {1'b0, cap}) begin
      s = s - {1'b0, cap};
    end
    return s[8:0];
  endfunction

  // Register port state.
  logic [7:0]       addr;
  logic [7:0]       cfg;
  byte_phase_t      phase;
  logic [7:0]       rdata;
  logic             rvalid;
  logic [7:0]       next_addr;
  logic [7:0]       next_cfg;
  byte_phase_t      next_phase;
  logic [7:0]       next_rdata;
  logic             next_rvalid;
  logic [7:0]       eff_addr;
  logic             consume;
  logic             mode_change;
  byte_phase_t      start_phase;
  byte_phase_t      ph_eff;
  queue_mode_t      mode;
  logic             tag_en;

  // Queue state.
  logic [8:0]       wr_ptr;
  logic [8:0]       rd_ptr;
  logic [8:0]       count;
  logic [1:0]       wr_slot;
  logic [1:0]       rd_slot;
  logic             settle;
  logic             trig_seen;
  logic [8:0]       post_left;
  logic             frozen;
  logic [3:0]       en;
  logic [8:0]       next_wr_ptr;
  logic [8:0]       next_rd_ptr;
  logic [8:0]       next_count;
  logic [1:0]       next_wr_slot;
  logic [1:0]       next_rd_slot;
  logic             next_settle;
  logic             next_trig_seen;
  logic [8:0]       next_post_left;
  logic             next_frozen;
  logic [3:0]       next_en;

  logic [2:0]       nchan;
  logic [8:0]       cap;
  logic             full;
  logic             flush;
  logic             write_en;
  logic             overwrite;
  logic             storing;
  logic             match;
  logic             pop_valid;
  logic             pop_ready;
  logic [17:0]      pop_word;
  logic [15:0]      mem [QUEUE_WORDS];
  logic [15:0]      mem_q;

  assign mode   = queue_mode_t'(cfg[MODE_LSB +: 2]);
  assign tag_en = cfg[TAG_ENABLE_BIT];
  assign nchan  = 3'(en[0]) + 3'(en[1]) + 3'(en[2]) + 3'(en[3]);
  assign cap    = (nchan == 3'h3) ? CAP_THREE_CHAN : CAP_FULL;
  assign full   = (count == cap);

  // Input samples are buffered so that a stalled queue pushes back on the sampler.
  sample_fifo #(
    .WIDTH (SAMPLE_W + 2),
    .DEPTH (INPUT_FIFO_DEPTH)
  ) u_in_fifo (
    .clk_in        (CORE_CLK_IN),
    .rst_n_in      (RST_N_IN),
    .in_valid_in   (SAMPLE_VALID_IN),
    .in_data_in    ({SAMPLE_CHAN_IN, SAMPLE_DATA_IN}),
    .in_ready_out  (SAMPLE_READY_OUT),
    .out_valid_out (pop_valid),
    .out_data_out  (pop_word),
    .out_ready_in  (pop_ready)
  );

  // Register port: byte accesses at an address that walks up to the data port.
  always_comb begin
    eff_addr    = REG_START_IN ? REG_ADDR_IN : addr;
    next_addr   = addr;
    next_cfg    = cfg;
    next_phase  = phase;
    next_rdata  = rdata;
    next_rvalid = REG_RD_IN;
    consume     = 1'b0;
    mode_change = 1'b0;
    start_phase = tag_en ? PH_TAG : PH_LOW;
    ph_eff      = (phase == PH_TAG && !tag_en) ? PH_LOW : phase;
    if (REG_RD_IN || REG_WR_IN) begin
      next_addr = (eff_addr == QUEUE_READ_PORT_ADDR) ? eff_addr : eff_addr + 8'h01;
    end else if (REG_START_IN) begin
      next_addr = REG_ADDR_IN;
    end
    if (REG_WR_IN && eff_addr == QUEUE_CONFIG_LOW_ADDR) begin
      next_cfg    = REG_WDATA_IN;
      mode_change = (REG_WDATA_IN[MODE_LSB +: 2] != cfg[MODE_LSB +: 2]);
      // A new tag setting restarts the byte order, or the first tag would be skipped.
      start_phase = REG_WDATA_IN[TAG_ENABLE_BIT] ? PH_TAG : PH_LOW;
      next_phase  = start_phase;
    end
    if (REG_RD_IN) begin
      case (eff_addr)
        QUEUE_READ_PORT_ADDR: begin
          // An empty or disabled queue reads as zero and leaves the byte order alone.
          if (mode == MODE_OFF || !settle) begin
            next_rdata = 8'h00;
          end else begin
            case (ph_eff)
              PH_TAG: begin
                next_rdata = {6'h00, slot_chan(en, rd_slot)};
                next_phase = PH_LOW;
              end
              PH_LOW: begin
                next_rdata = mem_q[7:0];
                next_phase = PH_HIGH;
              end
              PH_HIGH: begin
                next_rdata = mem_q[15:8];
                next_phase = start_phase;
                consume    = 1'b1;
              end
              default: begin
                next_rdata = 8'h00;
                next_phase = start_phase;
              end
            endcase
          end
        end
        QUEUE_CONFIG_LOW_ADDR: begin
          next_rdata = cfg;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
    // A dropped set or a flush would leave the host mid-word on stale data.
    if (overwrite || flush) begin
      next_phase = start_phase;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      addr   <= 8'h00;
      cfg    <= QUEUE_CONFIG_LOW_RESET;
      phase  <= PH_LOW;
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      addr   <= next_addr;
      cfg    <= next_cfg;
      phase  <= next_phase;
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // Queue: write side, overwrite of the oldest set, and trigger freeze.
  always_comb begin
    flush     = (mode == MODE_OFF) || mode_change || (CHAN_ENABLE_IN != en);
    storing   = (mode != MODE_OFF) && !frozen && (nchan != 3'h0);
    match     = en[pop_word[17:16]] && (pop_word[17:16] == slot_chan(en, wr_slot));
    write_en  = pop_valid && storing && match && !flush && (!full || mode != MODE_STOP);
    overwrite = write_en && full;
    // Stop mode holds the sample back until the host frees a word.
    pop_ready = !(storing && match && !flush && full && mode == MODE_STOP);
    next_en        = CHAN_ENABLE_IN;
    next_wr_ptr    = wr_ptr;
    next_rd_ptr    = rd_ptr;
    next_wr_slot   = wr_slot;
    next_rd_slot   = rd_slot;
    next_count     = count;
    next_trig_seen = trig_seen;
    next_post_left = post_left;
    next_frozen    = frozen;
    next_settle    = (count != 9'h000) && !overwrite && !consume && !flush;
    if (flush) begin
      next_wr_ptr    = 9'h000;
      next_rd_ptr    = 9'h000;
      next_wr_slot   = 2'h0;
      next_rd_slot   = 2'h0;
      next_count     = 9'h000;
      next_trig_seen = 1'b0;
      next_frozen    = 1'b0;
    end else begin
      if (write_en) begin
        next_wr_ptr  = ptr_add(wr_ptr, 3'h1, cap);
        next_wr_slot = (3'(wr_slot) + 3'h1 == nchan) ? 2'h0 : wr_slot + 2'h1;
      end
      if (overwrite) begin
        next_rd_ptr = ptr_add(rd_ptr, nchan, cap);
        next_count  = count + 9'h001 - 9'(nchan);
      end else begin
        if (consume) begin
          next_rd_ptr  = ptr_add(rd_ptr, 3'h1, cap);
          next_rd_slot = (3'(rd_slot) + 3'h1 == nchan) ? 2'h0 : rd_slot + 2'h1;
        end
        next_count = count + 9'(write_en) - 9'(consume);
      end
      if (mode == MODE_TRIGGER && TRIGGER_IN && !trig_seen && !frozen) begin
        next_trig_seen = 1'b1;
        next_post_left = TRIGGER_SAMPLES_IN;
        next_frozen    = (TRIGGER_SAMPLES_IN == 9'h000);
      end else if (trig_seen && write_en) begin
        next_post_left = post_left - 9'h001;
        next_frozen    = (post_left == 9'h001);
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      wr_ptr    <= 9'h000;
      rd_ptr    <= 9'h000;
      count     <= 9'h000;
      wr_slot   <= 2'h0;
      rd_slot   <= 2'h0;
      settle    <= 1'b0;
      trig_seen <= 1'b0;
      post_left <= 9'h000;
      frozen    <= 1'b0;
      en        <= 4'h0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      wr_slot   <= next_wr_slot;
      rd_slot   <= next_rd_slot;
      settle    <= next_settle;
      trig_seen <= next_trig_seen;
      post_left <= next_post_left;
      frozen    <= next_frozen;
      en        <= next_en;
    end
  end

  // The head word is read one cycle after the pointer settles; settle covers that gap.
  always_ff @(posedge CORE_CLK_IN) begin
    if (write_en) begin
      mem[wr_ptr] <= pop_word[15:0];
    end
    mem_q <= mem[rd_ptr];
  end

  assign REG_RDATA_OUT    = rdata;
  assign REG_RVALID_OUT   = rvalid;
  assign QUEUE_FULL_OUT   = full;
  assign QUEUE_READY_OUT  = (count != 9'h000);
  assign QUEUE_FROZEN_OUT = frozen;

endmodule

// [dv/queue_checker_asserts.sv]
`timescale 1ns/100ps
module queue_checker
  import accel_queue_pkg::*;
(
  input wire logic       CORE_CLK_IN,
  input wire logic       RST_N_IN,
  input wire logic       REG_START_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic       REG_RD_IN,
  input wire logic       REG_WR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic       REG_RVALID_OUT,
  input wire logic [3:0] CHAN_ENABLE_IN,
  input wire logic       QUEUE_FULL_OUT,
  input wire logic       QUEUE_READY_OUT,
  input wire logic       QUEUE_FROZEN_OUT
);
  queue_mode_t mode;
  queue_mode_t next_mode;

  // Only writes that start at the config address are tracked; the bench writes it that way.
  always_comb begin
    next_mode = mode;
    if (REG_START_IN && REG_WR_IN && REG_ADDR_IN == QUEUE_CONFIG_LOW_ADDR) begin
      next_mode = queue_mode_t'(REG_WDATA_IN[MODE_LSB +: 2]);
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      mode <= MODE_OFF;
    end else begin
      mode <= next_mode;
    end
  end

  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_read_answers: assert property (REG_RD_IN |=> REG_RVALID_OUT)
    else $error("read byte got no answer");
  a_no_stray_answer: assert property (!REG_RD_IN |=> !REG_RVALID_OUT)
    else $error("answer without a read");
  a_rdata_holds: assert property (!REG_RD_IN |=> $stable(REG_RDATA_OUT))
    else $error("read byte changed without a read");
  a_reset_clears: assert property (disable iff (1'b0) !RST_N_IN |=>
    !QUEUE_READY_OUT && !QUEUE_FULL_OUT && !REG_RVALID_OUT)
    else $error("flags not cleared by reset");
  a_full_has_data: assert property (QUEUE_FULL_OUT |-> QUEUE_READY_OUT)
    else $error("full without ready");
  a_off_reads_zero: assert property ((mode == MODE_OFF && REG_START_IN && REG_RD_IN
    && REG_ADDR_IN == QUEUE_READ_PORT_ADDR) |=> REG_RDATA_OUT == 8'h00)
    else $error("disabled queue read not zero");
  a_off_stays_empty: assert property (mode == MODE_OFF [*4] |-> !QUEUE_READY_OUT)
    else $error("disabled queue holds data");
  a_freeze_in_trigger: assert property ($rose(QUEUE_FROZEN_OUT) |-> mode == MODE_TRIGGER)
    else $error("freeze outside trigger mode");
  a_frozen_holds: assert property ((QUEUE_FROZEN_OUT && mode == MODE_TRIGGER
    && !REG_WR_IN && $stable(CHAN_ENABLE_IN)) |=> QUEUE_FROZEN_OUT)
    else $error("frozen history released");

  c_full: cover property (QUEUE_FULL_OUT);
  c_frozen: cover property (QUEUE_FROZEN_OUT);
  c_stop_read: cover property (REG_RVALID_OUT && mode == MODE_STOP);
endmodule

bind accel_sample_queue queue_checker queue_checker_i (.CORE_CLK_IN, .RST_N_IN, .REG_START_IN,
  .REG_ADDR_IN, .REG_RD_IN, .REG_WR_IN, .REG_WDATA_IN, .REG_RDATA_OUT, .REG_RVALID_OUT,
  .CHAN_ENABLE_IN, .QUEUE_FULL_OUT, .QUEUE_READY_OUT, .QUEUE_FROZEN_OUT);

// [dv/queue_host.sv]
`timescale 1ns/100ps
module queue_host (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in,
  output logic            start_out,
  output logic      [7:0] addr_out,
  output logic            rd_out,
  output logic            wr_out,
  output logic      [7:0] wdata_out
);
  initial begin
    start_out = 1'b0;
    addr_out = 8'h00;
    rd_out = 1'b0;
    wr_out = 1'b0;
    wdata_out = 8'h00;
  end

  // Released lines show the inverse of their last value so stale data is never mistaken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    start_out = 1'b1;
    addr_out = a;
    wr_out = 1'b1;
    wdata_out = d;
    @(negedge clk_in);
    start_out = 1'b0;
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask

  // The answer stands only from the edge after the request to the next one, so it is taken
  // at the falling edge in between, before the request is released.
  task automatic rd(input logic s, input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk_in);
    start_out = s;
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    d = rdata_in;
    v = rvalid_in;
    start_out = 1'b0;
    rd_out = 1'b0;
    addr_out = ~a;
  endtask
endmodule

// [dv/tb.sv]
`timescale 1ns/100ps
module tb;
  import accel_queue_pkg::*;
  logic        clk, rst_n, start, rd, wr, rvalid, s_valid, s_ready, trig, full, ready, frozen;
  logic        v;
  logic [7:0]  addr, wdata, rdata, b;
  logic [3:0]  chan_en;
  logic [1:0]  s_chan;
  logic [15:0] s_data;
  logic [8:0]  trig_n;
  int          miscompares;
  int          n_checks;

  accel_sample_queue accel_sample_queue_i (.CORE_CLK_IN(clk), .RST_N_IN(rst_n),
    .REG_START_IN(start), .REG_ADDR_IN(addr), .REG_RD_IN(rd), .REG_WR_IN(wr),
    .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
    .CHAN_ENABLE_IN(chan_en), .SAMPLE_VALID_IN(s_valid), .SAMPLE_CHAN_IN(s_chan),
    .SAMPLE_DATA_IN(s_data), .SAMPLE_READY_OUT(s_ready), .TRIGGER_IN(trig),
    .TRIGGER_SAMPLES_IN(trig_n), .QUEUE_FULL_OUT(full), .QUEUE_READY_OUT(ready),
    .QUEUE_FROZEN_OUT(frozen));
  queue_host queue_host_i (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid),
    .start_out(start), .addr_out(addr), .rd_out(rd), .wr_out(wr), .wdata_out(wdata));

  function automatic logic [15:0] sd_of(input int i);
    return {8'(i), ~8'(i)};
  endfunction

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic get(input logic s, input logic [7:0] a, input logic [7:0] exp);
    queue_host_i.rd(s, a, b, v);
    check({15'h0, v}, 16'h0001);
    check({8'h00, b}, {8'h00, exp});
  endtask

  // Word boundaries are spaced by three idle cycles so the head word has settled.
  task automatic word(input logic s, input logic tg, input logic [1:0] t, input logic [15:0] d);
    if (tg) begin
      get(s, QUEUE_READ_PORT_ADDR, {6'h00, t});
    end
    get(s && !tg, QUEUE_READ_PORT_ADDR, d[7:0]);
    get(1'b0, QUEUE_READ_PORT_ADDR, d[15:8]);
    repeat (2) @(negedge clk);
  endtask

  task automatic fill(input int lo, input int hi, input int nch);
    for (int i = lo; i < hi; i++) begin
      @(negedge clk);
      s_valid = 1'b1;
      s_chan = 2'(i % nch);
      s_data = sd_of(i);
      while (s_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
    end
    @(negedge clk);
    s_valid = 1'b0;
    s_data = ~s_data;
    repeat (12) @(negedge clk);
  endtask

  task end_test(input string n);
    $display("test %s done", n);
  endtask

  task stop_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // About 800 cycles are needed; the limit leaves a wide margin.
  initial begin
    #400000;
    miscompares++;
    stop_test;
  end

  initial begin
    rst_n = 1'b0;
    chan_en = 4'h7;
    s_valid = 1'b0;
    s_chan = 2'h0;
    s_data = 16'h0000;
    trig = 1'b0;
    trig_n = 9'h002;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    get(1'b1, QUEUE_CONFIG_LOW_ADDR, QUEUE_CONFIG_LOW_RESET);
    get(1'b1, QUEUE_READ_PORT_ADDR, 8'h00);
    check({14'h0, full, ready}, 16'h0000);
    end_test("reset");
    queue_host_i.wr(QUEUE_CONFIG_LOW_ADDR, 8'h50);
    get(1'b1, QUEUE_CONFIG_LOW_ADDR, 8'h50);
    fill(0, 318, 3);
    check({15'h0, full}, 16'h0001);
    for (int j = 0; j < 3; j++) word(j == 0, 1'b1, 2'(j), sd_of(j));
    repeat (4) @(negedge clk);
    check({15'h0, full}, 16'h0000);
    get(1'b1, 8'h1c, 8'h00);
    word(1'b0, 1'b1, TAG_X, sd_of(3));
    end_test("stop");
    chan_en = 4'hf;
    queue_host_i.wr(QUEUE_CONFIG_LOW_ADDR, 8'h20);
    fill(0, 324, 4);
    check({14'h0, full, ready}, 16'h0003);
    word(1'b1, 1'b0, TAG_X, sd_of(4));
    end_test("overwrite");
    chan_en = 4'h1;
    queue_host_i.wr(QUEUE_CONFIG_LOW_ADDR, 8'h30);
    fill(0, 8, 1);
    trig = 1'b1;
    @(negedge clk);
    trig = 1'b0;
    fill(8, 14, 1);
    check({15'h0, frozen}, 16'h0001);
    word(1'b1, 1'b0, TAG_X, sd_of(0));
    end_test("trigger");
    queue_host_i.wr(QUEUE_CONFIG_LOW_ADDR, 8'h00);
    repeat (4) @(negedge clk);
    check({13'h0, full, ready, frozen}, 16'h0000);
    get(1'b1, QUEUE_READ_PORT_ADDR, 8'h00);
    end_test("off");
    stop_test;
  end
endmodule
